// [eeprom_pkg.sv]
// constants, types and the bus-line carrier for the two-wire memory slave
// assumes a 100 MHz core clock; no software-visible registers exist
package eeprom_pkg;
	// array shape: 512 pages of 64 bytes, 15-bit word address (smaller variant)
	localparam int PAGE_W       = 6;
	localparam int PAGE_INDEX_W = 9;
	localparam int ADDR_W       = PAGE_INDEX_W + PAGE_W;
	localparam int NUM_PAGES    = 1 << PAGE_INDEX_W;
	// fixed upper nibble of the device address word
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	// bit counter marks: 8 rises make a byte, the 9th is the acknowledge clock
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_END = 4'h9;
	// timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int FILTER_TIME_NS  = 50;
	localparam int FILTER_CYCLES   = FILTER_TIME_NS / CLK_PERIOD_NS;
	localparam int PROGRAM_TIME_MS = 5;
	localparam int PROGRAM_CYCLES  = PROGRAM_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUSY_W          = 20;
	localparam int FILT_W          = 3;
	localparam logic LINE_IDLE     = 1'b1;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DEVADR  = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA   = 3'b100,
		ST_RDATA   = 3'b101,
		ST_BUSY    = 3'b110
	} state_type;

	typedef struct packed {
		logic scl;
		logic sda;
	} bus_lines_type;
endpackage : eeprom_pkg

// [line_filter.sv]
// three-stage synchroniser and glitch filter for one asynchronous pin
// assumes the pin is unrelated to the core clock; reset is already synchronous-released
`timescale 1ns/1ps
module line_filter #(
	parameter logic RESET_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic                        s1;
	logic                        s2;
	logic                        s3;
	logic                        level;
	logic [eeprom_pkg::FILT_W-1:0] cnt;
	logic                        next_level;
	logic [eeprom_pkg::FILT_W-1:0] next_cnt;

	// a new level must hold for the whole window before it is taken
	always_comb begin
		next_level = level;
		next_cnt   = '0;
		if (s2 == s3 && s3 != level) begin
			if (cnt == eeprom_pkg::FILT_W'(eeprom_pkg::FILTER_CYCLES - 1)) begin
				next_level = s3;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1    <= RESET_VAL;
			s2    <= RESET_VAL;
			s3    <= RESET_VAL;
			level <= RESET_VAL;
			cnt   <= '0;
		end else begin
			s1    <= pin_i;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
			cnt   <= next_cnt;
		end
	end

	assign level_o = level;

	AST_FILTER_HOLD: assert property (
		@(posedge clk_i) disable iff (!rstn_i)
		$changed(level) |-> $past(cnt) == eeprom_pkg::FILT_W'(eeprom_pkg::FILTER_CYCLES - 1))
		else $error("filtered level changed before the window elapsed");
endmodule : line_filter

// [eeprom_slave.sv]
// two-wire serial memory slave: framing, addressing, byte array, program busy time
// assumes an external pull-up on the data line and a bus master driving the clock line
//
// What this block does
// - device answers only when address bits match the three strap inputs
// - data line is only pulled low or released, never driven high
// - bits captured on clock rise; outgoing bits change after clock fall
// - write-protect low: reads and writes work normally
// - write-protect high: array never altered, reads still work
// - array is 512 pages; 64-byte pages with 15-bit word address
// - data change while clock high is framing, never a data bit
// - data fall with clock high is start; data rise is stop
// - each received byte except a mismatched device address is acknowledged low during the ninth clock
// - last address bit picks read or write; mismatch returns to standby
// - multi-byte write increments only in-page bits, wrapping within the page
`timescale 1ns/1ps
module eeprom_slave #(
	parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
	input  wire logic CORE_CLK_I,
	input  wire logic RSTN_I,
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	input  wire logic WP_I,
	input  wire logic STRAP_ADDR_BIT0_I,
	input  wire logic STRAP_ADDR_BIT1_I,
	input  wire logic STRAP_ADDR_BIT2_I,
	output logic      SDA_O,
	output logic      SDA_OE_N_O
);
	localparam int AW = eeprom_pkg::ADDR_W;

	logic                            rst_meta;
	logic                            rstn;
	eeprom_pkg::bus_lines_type       lines;
	eeprom_pkg::bus_lines_type       prev;
	logic                            wp;
	logic [2:0]                      strap;
	logic                            scl_rise;
	logic                            scl_fall;
	logic                            start;
	logic                            stop;
	logic                            match;
	eeprom_pkg::state_type           state;
	eeprom_pkg::state_type           next_state;
	logic [3:0]                      cnt;
	logic [3:0]                      next_cnt;
	logic [7:0]                      shreg;
	logic [7:0]                      next_shreg;
	logic [7:0]                      tx;
	logic [7:0]                      next_tx;
	logic [6:0]                      addr_hi;
	logic [6:0]                      next_addr_hi;
	logic [AW-1:0]                   addr;
	logic [AW-1:0]                   next_addr;
	logic                            rw;
	logic                            next_rw;
	logic                            oe_n;
	logic                            next_oe_n;
	logic                            mack;
	logic                            next_mack;
	logic                            wrote;
	logic                            next_wrote;
	logic [eeprom_pkg::BUSY_W-1:0]   busy_cnt;
	logic [eeprom_pkg::BUSY_W-1:0]   next_busy_cnt;
	logic                            sda_out;
	logic                            mem_we;
	logic [7:0]                      rd_byte;
	logic [7:0]                      mem [0:(1 << AW) - 1];

	// reset released through two flops so every flop leaves reset on one edge
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta <= 1'b0;
			rstn     <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rstn     <= rst_meta;
		end
	end

	line_filter #(.RESET_VAL(eeprom_pkg::LINE_IDLE)) u_scl (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(SCL_I), .level_o(lines.scl));
	line_filter #(.RESET_VAL(eeprom_pkg::LINE_IDLE)) u_sda (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(SDA_I), .level_o(lines.sda));
	line_filter #(.RESET_VAL(1'b1)) u_wp (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(WP_I), .level_o(wp));
	line_filter #(.RESET_VAL(1'b0)) u_strap0 (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(STRAP_ADDR_BIT0_I), .level_o(strap[0]));
	line_filter #(.RESET_VAL(1'b0)) u_strap1 (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(STRAP_ADDR_BIT1_I), .level_o(strap[1]));
	line_filter #(.RESET_VAL(1'b0)) u_strap2 (
		.clk_i(CORE_CLK_I), .rstn_i(rstn), .pin_i(STRAP_ADDR_BIT2_I), .level_o(strap[2]));

	assign scl_rise = lines.scl & ~prev.scl;
	assign scl_fall = ~lines.scl & prev.scl;
	// data moving with the clock held high is framing only
	assign start    = lines.scl & prev.scl & prev.sda & ~lines.sda;
	assign stop     = lines.scl & prev.scl & ~prev.sda & lines.sda;
	assign match    = shreg[7:4] == eeprom_pkg::DEV_TYPE_CODE && shreg[3:1] == strap;
	assign rd_byte  = mem[addr];

	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_shreg    = shreg;
		next_tx       = tx;
		next_addr_hi  = addr_hi;
		next_addr     = addr;
		next_rw       = rw;
		next_oe_n     = oe_n;
		next_mack     = mack;
		next_wrote    = wrote;
		next_busy_cnt = busy_cnt;
		mem_we        = 1'b0;
		if (state == eeprom_pkg::ST_BUSY) begin
			// inputs ignored while the array programs
			if (busy_cnt == eeprom_pkg::BUSY_W'(PROGRAM_CYCLES - 1)) begin
				next_state = eeprom_pkg::ST_IDLE;
			end else begin
				next_busy_cnt = busy_cnt + 1'b1;
			end
		end else if (start) begin
			next_state = eeprom_pkg::ST_DEVADR;
			next_cnt   = '0;
			next_oe_n  = 1'b1;
		end else if (stop) begin
			next_oe_n = 1'b1;
			next_wrote = 1'b0;
			next_busy_cnt = '0;
			next_state = wrote ? eeprom_pkg::ST_BUSY : eeprom_pkg::ST_IDLE;
		end else if (state == eeprom_pkg::ST_RDATA) begin
			if (scl_rise && cnt != eeprom_pkg::CNT_END) begin
				next_cnt = cnt + 1'b1;
				if (cnt == eeprom_pkg::CNT_ACK) begin
					next_mack = lines.sda;
				end
			end
			if (scl_fall) begin
				if (cnt < eeprom_pkg::CNT_ACK) begin
					next_oe_n = tx[6];
					next_tx   = {tx[6:0], 1'b0};
				end else if (cnt == eeprom_pkg::CNT_ACK) begin
					next_oe_n = 1'b1;
				end else if (!mack) begin
					next_tx   = rd_byte;
					next_oe_n = rd_byte[7];
					next_addr = AW'(addr + 1'b1);
					next_cnt  = '0;
				end else begin
					next_oe_n  = 1'b1;
					next_state = eeprom_pkg::ST_IDLE;
				end
			end
		end else if (state != eeprom_pkg::ST_IDLE) begin
			if (scl_rise && cnt != eeprom_pkg::CNT_END) begin
				next_cnt = cnt + 1'b1;
				if (cnt < eeprom_pkg::CNT_ACK) begin
					next_shreg = {shreg[6:0], lines.sda};
				end
			end
			if (scl_fall && cnt == eeprom_pkg::CNT_ACK) begin
				next_oe_n = 1'b0;
				case (state)
					eeprom_pkg::ST_DEVADR: begin
						next_rw = shreg[0];
						if (!match) begin
							next_oe_n  = 1'b1;
							next_state = eeprom_pkg::ST_IDLE;
						end
					end
					eeprom_pkg::ST_ADDR_HI: begin
						next_addr_hi = shreg[6:0];
					end
					eeprom_pkg::ST_ADDR_LO: begin
						next_addr = {addr_hi, shreg};
					end
					default: begin
						// protected writes are still acknowledged but never stored
						if (!wp) begin
							mem_we     = 1'b1;
							next_wrote = 1'b1;
						end
					end
				endcase
			end
			if (scl_fall && cnt == eeprom_pkg::CNT_END) begin
				next_oe_n = 1'b1;
				next_cnt  = '0;
				case (state)
					eeprom_pkg::ST_DEVADR: begin
						if (rw) begin
							next_state = eeprom_pkg::ST_RDATA;
							next_tx    = rd_byte;
							next_oe_n  = rd_byte[7];
							next_addr  = AW'(addr + 1'b1);
						end else begin
							next_state = eeprom_pkg::ST_ADDR_HI;
						end
					end
					eeprom_pkg::ST_ADDR_HI: next_state = eeprom_pkg::ST_ADDR_LO;
					eeprom_pkg::ST_ADDR_LO: next_state = eeprom_pkg::ST_WDATA;
					default: begin
						if (wrote) begin
							// upper page bits stay put so the page wraps on itself
							next_addr = {addr[AW-1:eeprom_pkg::PAGE_W],
								addr[eeprom_pkg::PAGE_W-1:0] + 1'b1};
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge rstn) begin
		if (!rstn) begin
			state    <= eeprom_pkg::ST_IDLE;
			cnt      <= '0;
			shreg    <= '0;
			tx       <= '0;
			addr_hi  <= '0;
			addr     <= '0;
			rw       <= 1'b0;
			oe_n     <= 1'b1;
			mack     <= 1'b1;
			wrote    <= 1'b0;
			busy_cnt <= '0;
			prev     <= '1;
			sda_out  <= 1'b0;
		end else begin
			state    <= next_state;
			cnt      <= next_cnt;
			shreg    <= next_shreg;
			tx       <= next_tx;
			addr_hi  <= next_addr_hi;
			addr     <= next_addr;
			rw       <= next_rw;
			oe_n     <= next_oe_n;
			mack     <= next_mack;
			wrote    <= next_wrote;
			busy_cnt <= next_busy_cnt;
			prev     <= lines;
			sda_out  <= 1'b0;
		end
	end

	// array has no reset: content survives like nonvolatile cells
	always_ff @(posedge CORE_CLK_I) begin
		if (mem_we) begin
			mem[addr] <= shreg;
		end
	end

	assign SDA_O      = sda_out;
	assign SDA_OE_N_O = oe_n;

	AST_NEVER_HIGH: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		!SDA_O)
		else $error("data line driven high");
	AST_ACK_ON_MATCH: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		state == eeprom_pkg::ST_DEVADR && scl_fall && cnt == eeprom_pkg::CNT_ACK && match && !start && !stop
		|=> !SDA_OE_N_O && cnt == eeprom_pkg::CNT_ACK)
		else $error("matching address not acknowledged");
	AST_MISMATCH_IDLE: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		state == eeprom_pkg::ST_DEVADR && scl_fall && cnt == eeprom_pkg::CNT_ACK && !match && !start && !stop
		|=> state == eeprom_pkg::ST_IDLE && SDA_OE_N_O)
		else $error("mismatched address not back in standby");
	AST_WP_BLOCKS: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		wp |-> !mem_we)
		else $error("array written while protected");
	AST_WRITE_OPEN: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		state == eeprom_pkg::ST_WDATA && scl_fall && cnt == eeprom_pkg::CNT_ACK && !wp && !start && !stop
		|-> mem_we ##1 wrote)
		else $error("unprotected data byte not stored");
	AST_PAGE_WRAP: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		state == eeprom_pkg::ST_WDATA && scl_fall && cnt == eeprom_pkg::CNT_END && wrote && !start && !stop
		|=> addr[AW-1:eeprom_pkg::PAGE_W] == $past(addr[AW-1:eeprom_pkg::PAGE_W])
			&& addr[eeprom_pkg::PAGE_W-1:0] == eeprom_pkg::PAGE_W'($past(addr[eeprom_pkg::PAGE_W-1:0]) + 1'b1))
		else $error("write address left its page");
	AST_START_RESTARTS: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		start && state != eeprom_pkg::ST_BUSY |=> state == eeprom_pkg::ST_DEVADR && cnt == 4'h0 && SDA_OE_N_O)
		else $error("start did not restart the address phase");
	AST_OUT_ON_FALL: assert property (
		@(posedge CORE_CLK_I) disable iff (!rstn)
		$fell(SDA_OE_N_O) |-> $past(scl_fall))
		else $error("data line pulled low outside a clock fall");
endmodule : eeprom_slave

// [bus_master.sv]
// two-wire bus master model: open-drain data, clock runs only inside frames
// assumes a pull-up on the data wire; bit time is four quarters
`timescale 1ns/1ps
module bus_master #(
	parameter int QUARTER_NS = 80
) (
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	logic glitch;

	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
		glitch    = 1'b0;
	end

	// quarters are longer than the filter delay, so the slave answer settles before the rise
	// each data bit is set in the clock's low phase
	// glitches last 30 ns, under the filter window: a clock pulse in the low phase,
	// a data pulse in the high phase that would fake a start or stop if it got through
	task automatic bit_x(input logic b, output logic r);
		if (glitch) begin
			#20 scl_o = 1'b1;
			#30 scl_o = 1'b0;
		end
		#QUARTER_NS sda_low_o = ~b;
		#QUARTER_NS scl_o = 1'b1;
		if (glitch) begin
			#20 sda_low_o = b;
			#30 sda_low_o = ~b;
		end
		#QUARTER_NS r = sda_i;
		#QUARTER_NS scl_o = 1'b0;
	endtask : bit_x

	// start: data falls while clock high
	task automatic start();
		#QUARTER_NS sda_low_o = 1'b0;
		#QUARTER_NS scl_o = 1'b1;
		#QUARTER_NS sda_low_o = 1'b1;
		#QUARTER_NS scl_o = 1'b0;
	endtask : start

	// stop: data rises while clock high, clock then stands high
	task automatic stop();
		#QUARTER_NS sda_low_o = 1'b1;
		#QUARTER_NS scl_o = 1'b1;
		#QUARTER_NS sda_low_o = 1'b0;
		#QUARTER_NS;
	endtask : stop

	// msb first, then the ninth clock reads the slave acknowledge
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask : send_byte

	// master pulls low on the ninth clock to ask for one more byte
	task automatic recv_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(~more, r);
	endtask : recv_byte
endmodule : bus_master

// [testbench.sv]
// self-checking bench for the two-wire memory slave
// assumes a 100 MHz core clock and a pulled-up data wire
`timescale 1ns/1ps
module testbench;
	localparam int PROG = 200;
	logic       clk;
	logic       rstn;
	logic       wp;
	logic [2:0] strap;
	logic       scl;
	logic       m_low;
	logic       sda_o;
	logic       sda_oe_n;
	logic       ack;
	logic [7:0] rd;
	logic [7:0] wd [4];
	int         n_fail;
	int         n_tests;
	// open-drain wire: low if anyone pulls, else the pull-up wins
	wire logic  sda = (m_low || (sda_oe_n === 1'b0)) ? 1'b0 : 1'b1;

	eeprom_slave #(
		.PROGRAM_CYCLES(PROG)
	) u_dut (
		.CORE_CLK_I       (clk),
		.RSTN_I           (rstn),
		.SCL_I            (scl),
		.SDA_I            (sda),
		.WP_I             (wp),
		.STRAP_ADDR_BIT0_I(strap[0]),
		.STRAP_ADDR_BIT1_I(strap[1]),
		.STRAP_ADDR_BIT2_I(strap[2]),
		.SDA_O            (sda_o),
		.SDA_OE_N_O       (sda_oe_n)
	);

	bus_master u_master (
		.sda_i    (sda),
		.scl_o    (scl),
		.sda_low_o(m_low)
	);

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic set_addr(input logic [15:0] a);
		u_master.start();
		u_master.send_byte({eeprom_pkg::DEV_TYPE_CODE, strap, 1'b0}, ack);
		chk_bit("dev ack", 1'b1, ack);
		u_master.send_byte(a[15:8], ack);
		chk_bit("hi ack", 1'b1, ack);
		u_master.send_byte(a[7:0], ack);
		chk_bit("lo ack", 1'b1, ack);
	endtask : set_addr

	task automatic read_cur(input int n, input int first);
		u_master.start();
		u_master.send_byte({eeprom_pkg::DEV_TYPE_CODE, strap, 1'b1}, ack);
		chk_bit("rd dev ack", 1'b1, ack);
		for (int i = 0; i < n; i++) begin
			u_master.recv_byte(i < n - 1, rd);
			chk_byte("rd data", wd[first + i], rd);
		end
		u_master.stop();
	endtask : read_cur

	task automatic poll(output logic a);
		u_master.start();
		u_master.send_byte({eeprom_pkg::DEV_TYPE_CODE, strap, 1'b0}, a);
		u_master.stop();
	endtask : poll

	// every device code is tried; only the strapped one answers
	task automatic t_straps(input logic [2:0] s);
		repeat (20) @(posedge clk);
		@(posedge clk) #1 strap = s;
		for (int i = 0; i < 8; i++) begin
			u_master.start();
			u_master.send_byte({eeprom_pkg::DEV_TYPE_CODE, 3'(i), 1'b0}, ack);
			chk_bit("strap ack", 3'(i) == s, ack);
			chk_bit("drive value", 1'b0, sda_o);
			u_master.stop();
		end
	endtask : t_straps

	// page write across the page end with the ignored top address bit set
	task automatic t_page_write();
		logic a;
		wd = '{8'hA5, 8'h3C, 8'h96, 8'h0F};
		set_addr(16'h813E);
		for (int i = 0; i < 4; i++) begin
			u_master.send_byte(wd[i], ack);
			chk_bit("wr ack", 1'b1, ack);
		end
		u_master.stop();
		poll(a);
		chk_bit("busy poll", 1'b0, a);
		repeat (PROG + 20) @(posedge clk) #1;
		poll(a);
		chk_bit("ready poll", 1'b1, a);
		set_addr(16'h013E);
		read_cur(2, 0);
		set_addr(16'h0100);
		read_cur(1, 2);
		read_cur(1, 3);
	endtask : t_page_write

	// protected write is acknowledged, starts no busy time, stores nothing
	task automatic t_protect();
		logic a;
		wd[0] = 8'h5A;
		set_addr(16'h0200);
		u_master.send_byte(wd[0], ack);
		u_master.stop();
		repeat (PROG + 20) @(posedge clk);
		@(posedge clk) #1 wp = 1'b1;
		u_master.glitch = 1'b1;
		set_addr(16'h0200);
		u_master.send_byte(~wd[0], ack);
		chk_bit("wp data ack", 1'b1, ack);
		u_master.stop();
		poll(a);
		chk_bit("wp no busy", 1'b1, a);
		u_master.glitch = 1'b0;
		set_addr(16'h0200);
		read_cur(1, 0);
		@(posedge clk) #1 wp = 1'b0;
	endtask : t_protect

	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// the run needs about 180 us; a hang is cut at 500 us
	initial begin
		#500000;
		n_fail++;
		results();
	end

	initial begin
		n_fail  = 0;
		n_tests = 0;
		rstn    = 1'b0;
		wp      = 1'b0;
		strap   = 3'b101;
		repeat (5) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (20) @(posedge clk);
		t_straps(3'b010);
		t_straps(3'b101);
		t_page_write();
		t_protect();
		results();
	end
endmodule : testbench
